/* File: logic/sadc_cfg.svh */
// constants for the successive-approximation converter control block
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
// register indices (printed offsets); byte address is four times the index
`define SADC_IDX_RESULT   8'h70
`define SADC_IDX_CSR      8'h71
`define SADC_ADDR_RESULT  10'h1c0
`define SADC_ADDR_CSR     10'h1c4
// control/status field positions
`define SADC_BIT_DONE     7
`define SADC_BIT_RSV6     6
`define SADC_BIT_ON       5
`define SADC_BIT_RSV4     4
`define SADC_CH_MSB       3
`define SADC_CH_LSB       0
// reset values
`define SADC_RST_RESULT   8'h00
`define SADC_RST_CSR      8'h00
// sequencing
`define SADC_CONV_PERIODS 4'hc
`define SADC_LOAD_PERIODS 4'h4
`define SADC_RES_BITS     4'h8
`define SADC_MSB_TRIAL    8'h80
`define SADC_ZERO8        8'h00
`define SADC_ZERO32       32'h00000000
// ahb encodings
`define SADC_HTRANS_NONSEQ 2'h2
`define SADC_HRESP_OKAY    1'b0
`endif

/* File: logic/sadc_pkg.sv */
// types for the successive-approximation converter control block
package sadc_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		SADC_OFF,
		SADC_LOAD,
		SADC_CONV
	} sadc_state_t;

	// control/status register as stored
	typedef struct packed {
		logic       done;
		logic       on;
		logic [3:0] channel;
	} sadc_csr_t;

	// analog front end controls
	typedef struct packed {
		logic       powered;
		logic       sample;
		logic [3:0] channel;
		logic [7:0] trial;
	} sadc_afe_t;
endpackage

/* File: logic/sadc_ctrl.sv */
// converter sequencer and ahb-lite register slave
// Notes on behaviour
// - sample phase first, then capacitor isolated for eight approximation steps
// - while on, sampling and conversion repeat back to back unattended
// - whole conversion spans twelve converter periods, converter clock is cpu/2
// - input at or above upper reference yields ff, no overflow flag
// - input at or below lower reference yields 00
// - setting converter_on powers up, starts conversion, then converts continuously
// - each finished conversion sets done flag bit 7, never an interrupt
// - result stays stable until the next conversion finishes
// - csr write while on aborts, clears done flag, restarts conversion
// - done flag cleared by result read or csr write, not settable by software
// - converter_on read/write; zero switches off, one switches on
// - four-bit channel_select picks input 0 to 15 in binary
// - bits 6 and 4 reserved, read as zero, writes ignored
// - cpu wait mode leaves the converter running unchanged
// - halt mode disables the converter; software allows settling afterwards
// - result register read-only, unsigned 00 to ff, writes ignored
// - both registers reset to 00: off, channel 0, flag clear
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "sadc_cfg.svh"

module sadc_ctrl (
	input  wire logic              hclk,          // cpu clock, 100 mhz
	input  wire logic              hresetn,       // async reset, active low
	input  wire logic              hsel,          // slave select
	input  wire logic [31:0]       haddr,         // byte address
	input  wire logic [1:0]        htrans,        // transfer type
	input  wire logic              hwrite,        // write when high
	input  wire logic [2:0]        hsize,         // transfer size
	input  wire logic [31:0]       hwdata,        // write data
	input  wire logic              hready,        // bus ready in
	output logic      [31:0]       hrdata,        // read data
	output logic                   hreadyout,     // always ready
	output logic                   hresp,         // always okay
	input  wire logic              halt_mode,     // cpu halt, stops converter
	input  wire logic              wait_mode,     // cpu wait, no effect
	input  wire logic              comp_above,    // comparator: input >= trial code
	output sadc_pkg::sadc_afe_t    afe            // analog front end controls
);
	import sadc_pkg::*;

	sadc_state_t state_r;
	sadc_csr_t   csr_r;
	logic [7:0]  result_r;
	logic [7:0]  sar_r;
	logic [7:0]  bit_r;
	logic [3:0]  per_r;
	logic        div_r;
	logic        ap_wr_r;
	logic        ap_rd_r;
	logic [9:0]  ap_addr_r;
	logic        wr_csr;
	logic        rd_res;
	logic        tick;
	logic        last;
	logic        run;

	// address decode shared by read and write paths
	function automatic logic is_addr(input logic [9:0] a, input logic [9:0] target);
		is_addr = (a == target);
	endfunction

	// ahb address phase capture; only word accesses are issued by the master
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r   <= 1'b0;
			ap_rd_r   <= 1'b0;
			ap_addr_r <= 10'h000;
		end else if (hready) begin
			ap_wr_r   <= hsel && (htrans == `SADC_HTRANS_NONSEQ) && hwrite;
			ap_rd_r   <= hsel && (htrans == `SADC_HTRANS_NONSEQ) && !hwrite;
			ap_addr_r <= haddr[9:0];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = `SADC_HRESP_OKAY;
	assign wr_csr    = ap_wr_r && is_addr(ap_addr_r, `SADC_ADDR_CSR);
	assign rd_res    = ap_rd_r && is_addr(ap_addr_r, `SADC_ADDR_RESULT);
	// halt gates the converter off; wait_mode deliberately unused by the sequencer
	assign run       = csr_r.on && !halt_mode;
	assign tick      = div_r;
	assign last      = (per_r == (`SADC_CONV_PERIODS - 4'h1));

	// read data combinational from stored state; unmapped reads give zero
	always_comb begin
		hrdata = `SADC_ZERO32;
		if (ap_rd_r && is_addr(ap_addr_r, `SADC_ADDR_RESULT)) begin
			hrdata[7:0] = result_r;
		end else if (ap_rd_r && is_addr(ap_addr_r, `SADC_ADDR_CSR)) begin
			hrdata[`SADC_BIT_DONE]             = csr_r.done;
			hrdata[`SADC_BIT_RSV6]             = 1'b0;
			hrdata[`SADC_BIT_ON]               = csr_r.on;
			hrdata[`SADC_BIT_RSV4]             = 1'b0;
			hrdata[`SADC_CH_MSB:`SADC_CH_LSB]  = csr_r.channel;
		end
	end

	// converter clock enable, one hclk in two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 1'b0;
		end else begin
			div_r <= !div_r;
		end
	end

	// control fields and done flag in one process so the struct has one driver;
	// reserved bits are not stored at all; set at conversion end beats a result-read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csr_r.on      <= 1'b0;
			csr_r.channel <= 4'h0;
			csr_r.done    <= 1'b0;
		end else begin
			if (wr_csr) begin
				csr_r.on      <= hwdata[`SADC_BIT_ON];
				csr_r.channel <= hwdata[`SADC_CH_MSB:`SADC_CH_LSB];
			end
			if (wr_csr) begin
				csr_r.done <= 1'b0;
			end else if (run && tick && state_r == SADC_CONV && last) begin
				csr_r.done <= 1'b1;
			end else if (rd_res) begin
				csr_r.done <= 1'b0;
			end
		end
	end

	// sequencer: load for four periods, eight trial periods, repeat
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= SADC_OFF;
			per_r   <= 4'h0;
			sar_r   <= `SADC_ZERO8;
			bit_r   <= `SADC_ZERO8;
		end else if (!run || wr_csr) begin
			// a csr write restarts from sampling; wr_csr takes effect after the write
			state_r <= SADC_OFF;
			per_r   <= 4'h0;
			sar_r   <= `SADC_ZERO8;
			bit_r   <= `SADC_ZERO8;
		end else if (tick) begin
			case (state_r)
				SADC_OFF: begin
					state_r <= SADC_LOAD;
					per_r   <= 4'h0;
				end
				SADC_LOAD: begin
					per_r <= per_r + 4'h1;
					if (per_r == (`SADC_LOAD_PERIODS - 4'h1)) begin
						state_r <= SADC_CONV;
						sar_r   <= `SADC_MSB_TRIAL;
						bit_r   <= `SADC_MSB_TRIAL;
					end
				end
				SADC_CONV: begin
					// comparator verdict on the current trial bit, then next lower
					sar_r <= (comp_above ? sar_r : (sar_r & ~bit_r)) | (bit_r >> 1);
					bit_r <= bit_r >> 1;
					if (last) begin
						state_r <= SADC_LOAD;
						per_r   <= 4'h0;
					end else begin
						per_r <= per_r + 4'h1;
					end
				end
				default: begin
					state_r <= SADC_OFF;
				end
			endcase
		end
	end

	// result updated only at conversion end; bus writes never reach it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_r <= `SADC_RST_RESULT;
		end else if (run && !wr_csr && tick && state_r == SADC_CONV && last) begin
			result_r <= comp_above ? sar_r : (sar_r & ~bit_r);
		end
	end

	// front end drive from flip-flop state, except powered, which halt_mode gates directly
	always_comb begin
		afe.powered = run;
		afe.sample  = (state_r == SADC_LOAD);
		afe.channel = csr_r.channel;
		afe.trial   = sar_r;
	end
endmodule

/* File: verification/sadc_afe_model.sv */
// comparator and sample capacitor model
module sadc_afe_model (
	input	wire sadc_pkg::sadc_afe_t	afe,		// front end
	input	wire logic [15:0][7:0]		lv,		// input levels
	output	logic				comp_above	// compare out
);
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	logic [7:0]	held;
	// capacitor tracks its input only while sampling
	always_latch if (afe.sample) held <= lv[afe.channel];
	// unpowered answer is the inverted held lsb so stale logic cannot pass
	assign comp_above = afe.powered ? held >= afe.trial : ~held[0];
endmodule

/* File: verification/sadc_ctrl_checker.sv */
// port assertions for the converter control block
module sadc_ctrl_checker (
	input	wire logic			hclk,		// clock
	input	wire logic			hresetn,	// reset
	input	wire logic			hsel,		// select
	input	wire logic [31:0]		haddr,		// address
	input	wire logic [1:0]		htrans,		// type
	input	wire logic			hwrite,		// write
	input	wire logic			hready,		// ready
	input	wire logic [31:0]		hrdata,		// read data
	input	wire logic			halt_mode,	// halt
	input	wire sadc_pkg::sadc_afe_t	afe		// front end
);
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	logic	rd_csr_r;
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// data phase of a status read
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) rd_csr_r <= 1'b0;
		else rd_csr_r <= hsel && hready && htrans == 2'h2 && !hwrite && haddr[9:0] == 10'h1c4;
	// a full load phase, still powered
	sequence load_done;
		afe.sample [*8] ##1 !afe.sample && afe.powered;
	endsequence
	upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
	rsv_zero_a: assert property (rd_csr_r |-> !hrdata[6] && !hrdata[4]) else $error("reserved set");
	chan_echo_a: assert property (rd_csr_r |-> hrdata[3:0] == afe.channel) else $error("channel");
	on_echo_a: assert property (rd_csr_r && !halt_mode |-> hrdata[5] == afe.powered) else $error("on");
	halt_off_a: assert property (halt_mode |-> !afe.powered) else $error("halt power");
	halt_idle_a: assert property (halt_mode && $past(halt_mode) |-> !afe.sample) else $error("halt");
	reset_off_a: assert property (!$past(hresetn) |-> afe == 14'h0) else $error("reset afe");
	msb_first_a: assert property (load_done |-> ##[0:2] afe.trial == 8'h80) else $error("msb");
endmodule
bind sadc_ctrl sadc_ctrl_checker chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.halt_mode, .afe);

/* File: verification/sadc_ctrl_test.sv */
// self-checking bench for the converter control block
module sadc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	logic		hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, halt_mode = 1'b0, wait_mode = 1'b0;
	logic [31:0]	haddr = 32'h0, hwdata = 32'h0, seed = 32'h000113a0, hrdata, rd_q, r;
	logic [1:0]	htrans = 2'h0;
	logic [15:0][7:0] lv = '0;
	logic		hreadyout, hresp, comp_above, smp_q;
	logic [3:0]	ch;
	sadc_afe_t	afe;
	int		n_errors = 0, compares = 0, cyc = 0, last = 0, gap = 0;
	sadc_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .halt_mode, .wait_mode, .comp_above, .afe);
	sadc_afe_model afe_i (.afe, .lv, .comp_above);
	always #5 hclk = ~hclk;
	// read capture, random wait mode and hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		rd_q <= hrdata;
		wait_mode <= seed[cyc % 32];
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// spacing of load phases, off the launching edge
	always @(negedge hclk) begin
		smp_q <= afe.sample;
		if (afe.sample && !smp_q) begin
			gap <= cyc - last;
			last <= cyc;
		end
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one single transfer; read data captured at the answering edge
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		#1 q = rd_q;
	endtask
	task automatic chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// polls status until the done flag shows, bounded
	task automatic wait_done(output logic [31:0] q);
		for (int i = 0; i < 40; i++) begin
			bus(1'b0, 32'h1c4, 32'h0, q);
			if (q[7] === 1'b1) break;
		end
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'h1c0, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b0, 32'h1c4, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b0, 32'h1c8, 32'h0, r);
		chk(r, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		chk({31'h0, hreadyout}, 32'h1);
		// corner levels first, then random channels and levels
		for (int k = 0; k < 6; k++) begin
			for (int j = 0; j < 16; j++) begin
				seed = nx(seed);
				lv[j] <= (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
			end
			ch = seed[11:8];
			bus(1'b1, 32'h1c4, {28'h2, ch}, r);
			wait_done(r);
			chk(r, {28'ha, ch});
			bus(1'b0, 32'h1c0, 32'h0, r);
			chk(r, {24'h0, lv[ch]});
			bus(1'b0, 32'h1c4, 32'h0, r);
			chk(r, {28'h2, ch});
			wait_done(r);
			chk(r, {28'ha, ch});
			bus(1'b1, 32'h1c4, {28'h2, ch}, r);
			bus(1'b0, 32'h1c4, 32'h0, r);
			chk(r, {28'h2, ch});
		end
		repeat (80) @(posedge hclk);
		chk(gap, 32'd24);
		bus(1'b1, 32'h1c0, {24'h0, ~lv[ch]}, r);
		bus(1'b0, 32'h1c0, 32'h0, r);
		chk(r, {24'h0, lv[ch]});
		halt_mode <= 1'b1;
		bus(1'b1, 32'h1c4, {28'h2, ch}, r);
		repeat (60) @(posedge hclk);
		bus(1'b0, 32'h1c4, 32'h0, r);
		chk(r, {28'h2, ch});
		halt_mode <= 1'b0;
		wait_done(r);
		chk(r, {28'ha, ch});
		bus(1'b1, 32'h1c4, 32'h0, r);
		repeat (60) @(posedge hclk);
		bus(1'b0, 32'h1c4, 32'h0, r);
		chk(r, 32'h0);
		stop_test();
	end
endmodule
